/* File: inc/gpd_pkg.sv */
// Shared constants, types and helpers for the general-purpose I/O ports.
// Assumes a 32-bit APB slave with one 4 KB window per port.
`default_nettype none
package gpd_pkg;

    localparam int PORT_COUNT = 8;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 16;

    // Port select sits above the 4 KB window of each port
    localparam int PORT_SEL_LSB = 12;
    localparam int PORT_SEL_MSB = 14;
    localparam int SPACE_MSB = 15;

    // Offsets inside one port window
    localparam logic [11:0] OFF_DIRECTION = 12'h400;
    localparam logic [11:0] OFF_ALT_FUNC = 12'h420;
    localparam logic [11:0] OFF_PULL_UP = 12'h510;
    localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
    localparam logic [11:0] OFF_DIGITAL_EN = 12'h51C;

    // Data aperture: offset bits [11:10] zero, bits [9:2] are the mask
    localparam logic [1:0] APERTURE_TAG = 2'h0;
    localparam int MASK_LSB = 2;
    localparam int MASK_MSB = 9;

    // Port carrying the debug pins and which of its pins they are
    localparam int DEBUG_PORT = 2;
    localparam logic [7:0] DEBUG_PIN_MASK = 8'h0F;

    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] alt_function_select;
        logic [7:0] digital_input_enable;
        logic [7:0] pull_down_select;
        logic [7:0] pull_up_select;
    } gpd_pad_cfg_t;

    // True when an offset falls inside the masked data aperture
    function automatic logic gpd_in_aperture(input logic [11:0] offset);
        return offset[11:10] == APERTURE_TAG;
    endfunction

    // Per-bit mask carried on the address of a data access
    function automatic logic [7:0] gpd_addr_mask(input logic [11:0] offset);
        return offset[MASK_MSB:MASK_LSB];
    endfunction

endpackage
`default_nettype wire

/* File: rtl/gpd_gpio.sv */
// Eight general-purpose I/O ports behind one APB slave.
// Assumes pad_in comes from pins outside the pclk domain and that an
// external pad ring resolves pad_out/pad_oe into the real wire.
//
// Function
// RULE_01 - After reset every ordinary pin is undriven with alternate function, digital enable and both pulls cleared.
// RULE_02 - Port C pins 3 to 0 reset to their debug function with alternate function, digital enable and pull-up set.
// RULE_03 - Power-on reset and the external reset pin both restore every pin to its default.
// RULE_04 - The device holds eight identical, separately instantiated copies of one port block; the port C copy takes its own DEBUG_MASK.
// RULE_05 - A pin whose direction bit is zero is an input and its data bit captures the pin level.
// RULE_06 - A pin whose direction bit is one is an output and drives its data bit onto the pin; pad_oe also needs its alt function bit clear.
// RULE_07 - Address bits 9 to 2 of a data access form a per-bit mask over the eight data bits.
// RULE_08 - The data register answers at 256 word locations, one for every mask value.
// RULE_09 - A data write changes only the bits whose mask bit is one.
// RULE_10 - A data read returns real values for masked-in bits and zero for the rest.
// RULE_11 - Data bit n is masked by address bit n plus 2.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module gpd_port #(
    parameter logic [7:0] DEBUG_MASK = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [11:0] offset,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pad_in,
    output logic [7:0] rd_val,
    output logic rd_hit,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output gpd_pkg::gpd_pad_cfg_t pad_cfg
);

    logic [7:0] pin_direction;
    logic [7:0] pin_data_value;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_level;
    logic [7:0] mask;
    logic [7:0] next_data;
    logic data_wr;

    assign mask = gpd_pkg::gpd_addr_mask(offset); // RULE_07 RULE_11
    assign data_wr = wr_en && gpd_pkg::gpd_in_aperture(offset); // RULE_08

    // Three stages; a level counts only once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= gpd_pkg::RESET_ZERO;
            sync2 <= gpd_pkg::RESET_ZERO;
            sync3 <= gpd_pkg::RESET_ZERO;
        end else begin
            sync1 <= pad_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= gpd_pkg::RESET_ZERO;
        end else begin
            pin_level <= (pin_level & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
        end
    end

    always_comb begin
        next_data = pin_data_value;
        if (data_wr) begin
            next_data = (pin_data_value & ~mask) | (wdata & mask); // RULE_09
        end
    end

    // Input bits follow the pin, output bits hold what software wrote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_data_value <= gpd_pkg::RESET_ZERO;
        end else begin
            pin_data_value <= (next_data & pin_direction) | (pin_level & ~pin_direction); // RULE_05
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction <= gpd_pkg::RESET_ZERO; // RULE_01
        end else if (wr_en && offset == gpd_pkg::OFF_DIRECTION) begin
            pin_direction <= wdata;
        end
    end

    // Reset values are constants per instance; the debug port differs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_cfg.alt_function_select <= DEBUG_MASK; // RULE_01 RULE_02 RULE_03
            pad_cfg.digital_input_enable <= DEBUG_MASK; // RULE_01 RULE_02
            pad_cfg.pull_down_select <= gpd_pkg::RESET_ZERO; // RULE_01
            pad_cfg.pull_up_select <= DEBUG_MASK; // RULE_01 RULE_02
        end else if (wr_en) begin
            case (offset)
                gpd_pkg::OFF_ALT_FUNC: begin
                    pad_cfg.alt_function_select <= wdata;
                end
                gpd_pkg::OFF_DIGITAL_EN: begin
                    pad_cfg.digital_input_enable <= wdata;
                end
                gpd_pkg::OFF_PULL_DOWN: begin
                    pad_cfg.pull_down_select <= wdata;
                end
                gpd_pkg::OFF_PULL_UP: begin
                    pad_cfg.pull_up_select <= wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // A pin under its alternate function is left to that peripheral
    assign pad_out = pin_data_value; // RULE_06
    assign pad_oe = pin_direction & ~pad_cfg.alt_function_select; // RULE_06

    always_comb begin
        rd_val = gpd_pkg::RESET_ZERO;
        rd_hit = 1'b1;
        if (gpd_pkg::gpd_in_aperture(offset)) begin
            rd_val = pin_data_value & mask; // RULE_10
        end else begin
            case (offset)
                gpd_pkg::OFF_DIRECTION: begin
                    rd_val = pin_direction;
                end
                gpd_pkg::OFF_ALT_FUNC: begin
                    rd_val = pad_cfg.alt_function_select;
                end
                gpd_pkg::OFF_DIGITAL_EN: begin
                    rd_val = pad_cfg.digital_input_enable;
                end
                gpd_pkg::OFF_PULL_DOWN: begin
                    rd_val = pad_cfg.pull_down_select;
                end
                gpd_pkg::OFF_PULL_UP: begin
                    rd_val = pad_cfg.pull_up_select;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_data_write;
        data_wr;
    endsequence

    chk_reset_config: assert property ($rose(presetn) |-> // RULE_01 RULE_02 RULE_03
        pad_cfg == {DEBUG_MASK, DEBUG_MASK, 8'h00, DEBUG_MASK} && pad_oe == 8'h00)
        else $error("pad config wrong after reset");

    chk_input_capture: assert property (1'b1 |=> // RULE_05
        (pin_data_value & ~$past(pin_direction)) == ($past(pin_level) & ~$past(pin_direction)))
        else $error("input pin not captured");

    chk_output_drive: assert property (s_data_write ##1 (pin_direction == $past(pin_direction)) |-> // RULE_06
        ((pad_out ^ $past(wdata)) & $past(mask) & pin_direction) == 8'h00)
        else $error("written output not driven");

    chk_keep_unmasked: assert property (s_data_write |=> // RULE_09
        ((pin_data_value ^ $past(pin_data_value)) & ~$past(mask) & $past(pin_direction)) == 8'h00)
        else $error("unmasked bit changed");

    chk_mask_map: assert property (s_data_write ##0 (offset[9:2] == 8'h01 && pin_direction[0]) |=> // RULE_07 RULE_11
        pin_data_value[0] == $past(wdata[0]))
        else $error("bit 0 not tied to address bit 2");

    chk_read_mask: assert property (gpd_pkg::gpd_in_aperture(offset) |-> // RULE_10
        rd_val == (pin_data_value & offset[9:2]) && rd_hit)
        else $error("masked read wrong");

endmodule

module gpd_gpio #(
    parameter int NPORTS = gpd_pkg::PORT_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORTS-1:0][7:0] pad_in,
    output logic [NPORTS-1:0][7:0] pad_out,
    output logic [NPORTS-1:0][7:0] pad_oe,
    output gpd_pkg::gpd_pad_cfg_t [NPORTS-1:0] pad_cfg
);

    logic [NPORTS-1:0][7:0] rd_val;
    logic [NPORTS-1:0] rd_hit;
    logic [2:0] port_idx;
    logic space_ok;
    logic hit;

    assign port_idx = paddr[gpd_pkg::PORT_SEL_MSB:gpd_pkg::PORT_SEL_LSB];
    assign space_ok = !paddr[gpd_pkg::SPACE_MSB] && (32'(port_idx) < NPORTS);
    assign hit = space_ok && rd_hit[port_idx];

    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : gen_port
            gpd_port #(
                .DEBUG_MASK(g == gpd_pkg::DEBUG_PORT ? gpd_pkg::DEBUG_PIN_MASK : 8'h00) // RULE_02
            ) u_port ( // RULE_04
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(psel && penable && pwrite && space_ok && port_idx == 3'(g)),
                .offset(paddr[11:0]),
                .wdata(pwdata[7:0]),
                .pad_in(pad_in[g]),
                .rd_val(rd_val[g]),
                .rd_hit(rd_hit[g]),
                .pad_out(pad_out[g]),
                .pad_oe(pad_oe[g]),
                .pad_cfg(pad_cfg[g])
            );
        end
    endgenerate

    // Zero wait states; read data is caught in the setup cycle
    assign pready = psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= gpd_pkg::READ_ZERO;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= hit && !pwrite ? {24'h00_0000, rd_val[port_idx]} : gpd_pkg::READ_ZERO;
            pslverr <= !hit;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_aperture_ok: assert property (psel && !penable && paddr[15:10] == 6'h00 |=> // RULE_08
        pready && !pslverr)
        else $error("data aperture access refused");

    chk_unmapped_err: assert property (psel && !penable && paddr[15] |=>
        pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

`default_nettype wire

/* File: bench/gpd_gpio_tb.sv */
// Self-checking bench for the eight-port I/O block, driven over APB.
// Assumes gpd_pkg and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none

module gpd_gpio_tb;
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] wdata;
        logic [7:0] exp;
    } gpd_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0][7:0] pad_in = '0;
    logic [7:0][7:0] pad_out;
    logic [7:0][7:0] pad_oe;
    gpd_pkg::gpd_pad_cfg_t [7:0] pad_cfg;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] v;
    logic [11:0] offs [4] = '{gpd_pkg::OFF_ALT_FUNC, gpd_pkg::OFF_PULL_UP,
        gpd_pkg::OFF_PULL_DOWN, gpd_pkg::OFF_DIGITAL_EN};
    logic [7:0] cfg2 [4] = '{8'h0F, 8'h0F, 8'h00, 8'h0F};
    // Mask, write data, data value after the write
    gpd_row_t rows [7] = '{'{8'hFF, 8'h00, 8'h00}, '{8'h26, 8'hEB, 8'h22},
        '{8'hFF, 8'h5A, 8'h5A}, '{8'h80, 8'hFF, 8'hDA}, '{8'h02, 8'h00, 8'hD8},
        '{8'h00, 8'hFF, 8'hD8}, '{8'h01, 8'hFF, 8'hD9}};

    gpd_gpio i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .pad_cfg(pad_cfg)
    );

    always #4 pclk = ~pclk;

    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One edge passes first so psel is never set twice in one time step
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] ad(input int p, input logic [11:0] off);
        return {1'b0, 3'(p), off};
    endfunction

    task automatic chk_defaults;
        for (int p = 0; p < 8; p++) begin
            check(pad_cfg[p], p == 2 ? 32'h0F0F_000F : 32'h0000_0000);
            check({16'h0000, pad_oe[p], pad_out[p]}, 32'h0000_0000);
        end
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        chk_defaults();
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ad(2, offs[i]), 32'h0000_0000);
            check(rd, {24'h00_0000, cfg2[i]});
            apb(1'b0, ad(0, offs[i]), 32'h0000_0000);
            check(rd, 32'h0000_0000);
        end
        // Distinct value per port catches ports that alias each other
        for (int p = 0; p < 8; p++) begin
            v = {4'(p) ^ 4'hA, 4'(p)};
            apb(1'b1, ad(p, gpd_pkg::OFF_DIRECTION), 32'h0000_00FF);
            apb(1'b1, ad(p, gpd_pkg::OFF_ALT_FUNC), 32'h0000_0000);
            apb(1'b1, ad(p, 12'h3FC), {24'h00_0000, v});
        end
        @(posedge pclk);
        for (int p = 0; p < 8; p++) begin
            v = {4'(p) ^ 4'hA, 4'(p)};
            check({16'h0000, pad_oe[p], pad_out[p]}, {16'h0000, 8'hFF, v});
        end
        foreach (rows[i]) begin
            apb(1'b1, ad(3, {2'b00, rows[i].mask, 2'b00}), {24'hFF_FFFF, rows[i].wdata});
            @(posedge pclk);
            check({24'h00_0000, pad_out[3]}, {24'h00_0000, rows[i].exp});
            apb(1'b0, ad(3, {2'b00, rows[i].mask, 2'b00}), 32'h0000_0000);
            check(rd, {24'h00_0000, rows[i].exp & rows[i].mask});
        end
        apb(1'b1, ad(6, gpd_pkg::OFF_DIRECTION), 32'h0000_0000);
        pad_in[6] <= 8'hA5;
        repeat (10) @(posedge pclk);
        apb(1'b1, ad(6, 12'h3FC), 32'h0000_005A);
        apb(1'b0, ad(6, 12'h3C0), 32'h0000_0000);
        check(rd, 32'h0000_00A0);
        check({24'h00_0000, pad_oe[6]}, 32'h0000_0000);
        pad_in[6] <= 8'h3C;
        repeat (10) @(posedge pclk);
        apb(1'b0, ad(6, 12'h3FC), 32'h0000_0000);
        check(rd, 32'h0000_003C);
        apb(1'b0, ad(0, 12'h800), 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, 16'h8400, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b0, ad(0, gpd_pkg::OFF_DIRECTION), 32'h0000_0000);
        check(rd, 32'h0000_00FF);
        // Move every pad field of the debug port away from its default
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ad(2, offs[i]), 32'h0000_00F0);
            apb(1'b0, ad(2, offs[i]), 32'h0000_0000);
            check(rd, 32'h0000_00F0);
        end
        // Reset again in mid-run with every port reconfigured
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_defaults();
        presetn <= 1'b1;
        apb(1'b0, ad(2, gpd_pkg::OFF_ALT_FUNC), 32'h0000_0000);
        check(rd, 32'h0000_000F);
        report_and_stop();
    end
endmodule
`default_nettype wire
